// File: rtl/cwd_pkg.sv
// Purpose: Shared constants and types for the configuration word decoder.
// Assumes: 32-bit APB, 24-bit flash words, one clock.
// Notes:   Register byte address is four times the register index.

package cwd_pkg;

  // ------------------------------------------------------------------
  // Register indices
  // ------------------------------------------------------------------
  localparam logic [15:0] CWD_IDX_CTRL           = 16'h0000;
  localparam logic [15:0] CWD_IDX_STATUS         = 16'h0001;
  localparam logic [15:0] CWD_IDX_WORD_TWO_SMALL = 16'h2bfc;
  localparam logic [15:0] CWD_IDX_WORD_ONE_SMALL = 16'h2bfe;
  localparam logic [15:0] CWD_IDX_WORD_TWO_LARGE = 16'h57fc;
  localparam logic [15:0] CWD_IDX_WORD_ONE_LARGE = 16'h57fe;

  // Flash word addresses of the two configuration words.
  localparam logic [23:0] CWD_FLASH_TWO_SMALL = 24'h00_2bfc;
  localparam logic [23:0] CWD_FLASH_ONE_SMALL = 24'h00_2bfe;
  localparam logic [23:0] CWD_FLASH_TWO_LARGE = 24'h00_57fc;
  localparam logic [23:0] CWD_FLASH_ONE_LARGE = 24'h00_57fe;

  // ------------------------------------------------------------------
  // Reset values and read-back forcing
  // ------------------------------------------------------------------
  localparam logic [23:0] CWD_TWO_RESET  = 24'hff_ffdf;
  localparam logic [23:0] CWD_ONE_RESET  = 24'hff_ffff;
  localparam logic [23:0] CWD_TWO_FORCE1 = 24'hff_0008;
  localparam logic [23:0] CWD_ONE_FORCE1 = 24'hff_0400;

  // ------------------------------------------------------------------
  // Field positions, word two
  // ------------------------------------------------------------------
  localparam int CWD_W2_TWO_SPEED   = 15;
  localparam int CWD_W2_PWM_LOCK    = 14;
  localparam int CWD_W2_PWM_PIN     = 13;
  localparam int CWD_W2_WIN_LSB     = 11;
  localparam int CWD_W2_OSC_LSB     = 8;
  localparam int CWD_W2_CKSM_LSB    = 6;
  localparam int CWD_W2_OSC_PIN_FN  = 5;
  localparam int CWD_W2_PINMAP_ONCE = 4;
  localparam int CWD_W2_LOW_POL     = 3;
  localparam int CWD_W2_ALT_TWI     = 2;
  localparam int CWD_W2_PRI_LSB     = 0;

  // Field positions, word one.
  localparam int CWD_W1_CODE_PROT   = 13;
  localparam int CWD_W1_WRITE_PROT  = 12;
  localparam int CWD_W1_HIGH_POL    = 10;
  localparam int CWD_W1_DBG_LSB     = 8;
  localparam int CWD_W1_WDOG_FORCE  = 7;
  localparam int CWD_W1_WIN_DIS     = 6;
  localparam int CWD_W1_PLL_WAIT    = 5;
  localparam int CWD_W1_PRESCALE    = 4;
  localparam int CWD_W1_POST_LSB    = 0;

  // Watchdog scaling as log2 of the divide ratio.
  localparam logic [2:0] CWD_PRE_LOG2_HI = 3'h7;
  localparam logic [2:0] CWD_PRE_LOG2_LO = 3'h5;

  // Status register bit positions.
  localparam int CWD_ST_VALID = 0;
  localparam int CWD_ST_BUSY  = 1;
  localparam int CWD_ST_LARGE = 2;
  localparam int CWD_ST_OSCRS = 3;
  localparam int CWD_ST_DBGRS = 4;

  // ------------------------------------------------------------------
  // Types
  // ------------------------------------------------------------------
  typedef enum logic [2:0] {
    osc_fast_rc         = 3'h0,
    osc_div_fast_rc_pll = 3'h1,
    osc_primary         = 3'h2,
    osc_primary_pll     = 3'h3,
    osc_secondary       = 3'h4,
    osc_low_power_rc    = 3'h5,
    osc_reserved        = 3'h6,
    osc_div_fast_rc     = 3'h7
  } cwd_osc_t;

  typedef enum logic [1:0] {
    pri_ext_clock = 2'h0,
    pri_ms_xtal   = 2'h1,
    pri_hs_xtal   = 2'h2,
    pri_disabled  = 2'h3
  } cwd_pri_t;

  typedef struct packed {
    logic       code_protect_en;
    logic       write_protect_en;
    logic       two_speed_startup;
    cwd_osc_t   start_osc;
    cwd_osc_t   initial_osc_sel;
    logic       osc_sel_reserved;
    logic       pwm_key_lock;
    logic       pwm_pins_tristate;
    logic [2:0] wdog_window_eighths;
    logic       clk_switch_en;
    logic       fail_safe_en;
    logic       pinmap_one_shot;
    logic       osc_pin_clkout;
    logic       osc_pin_gpio;
    cwd_pri_t   primary_osc_mode;
    logic       primary_osc_en;
    logic       wdog_force_enable;
    logic       wdog_window_mode;
    logic       pll_lock_wait;
    logic [2:0] wdog_prescale_log2;
    logic [3:0] wdog_postscale_log2;
    logic [1:0] debug_pair;
    logic       debug_sel_reserved;
    logic       high_side_active_high;
    logic       low_side_active_high;
    logic       alt_two_wire_pins;
  } cwd_decoded_t;

endpackage

// File: rtl/cwd_top.sv
// Purpose: Loads the two flash configuration words into shadow registers and
//          decodes their fields into held device settings.
// Assumes: Flash read port answers with flash_rvalid some cycles after a request.
// Notes:   Shadow words are readable over APB; they cannot be written.
//
// Implementation choice: the APB register port.

`timescale 1ns/1ps

module cwd_top #(
  parameter bit LARGE_FLASH = 1'b0
) (
  input  wire logic                pclk,
  input  wire logic                presetn,
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [31:0]         paddr,
  input  wire logic [31:0]         pwdata,
  output logic                     pready,
  output logic                     pslverr,
  output logic [31:0]              prdata,
  output logic                     flash_rd_en,
  output logic [23:0]              flash_addr,
  input  wire logic [23:0]         flash_rdata,
  input  wire logic                flash_rvalid,
  input  wire logic                sw_wdog_enable,
  output logic                     wdog_run,
  output logic                     cfg_valid,
  output cwd_pkg::cwd_decoded_t    cfg
);
  import cwd_pkg::*;

  // ------------------------------------------------------------------
  // Loader state
  // ------------------------------------------------------------------
  typedef enum logic [4:0] {
    st_req_two  = 5'b00001,
    st_wait_two = 5'b00010,
    st_req_one  = 5'b00100,
    st_wait_one = 5'b01000,
    st_done     = 5'b10000
  } cwd_state_t;

  localparam logic [23:0] FLASH_TWO = LARGE_FLASH ? CWD_FLASH_TWO_LARGE : CWD_FLASH_TWO_SMALL;
  localparam logic [23:0] FLASH_ONE = LARGE_FLASH ? CWD_FLASH_ONE_LARGE : CWD_FLASH_ONE_SMALL;
  localparam logic [15:0] IDX_TWO   = LARGE_FLASH ? CWD_IDX_WORD_TWO_LARGE
                                                  : CWD_IDX_WORD_TWO_SMALL;
  localparam logic [15:0] IDX_ONE   = LARGE_FLASH ? CWD_IDX_WORD_ONE_LARGE
                                                  : CWD_IDX_WORD_ONE_SMALL;

  cwd_state_t   state_r;
  cwd_state_t   state_nxt;
  logic [23:0]  shadow_two_r;
  logic [23:0]  shadow_two_nxt;
  logic [23:0]  shadow_one_r;
  logic [23:0]  shadow_one_nxt;
  logic [23:0]  flash_addr_r;
  logic [23:0]  flash_addr_nxt;
  logic         valid_r;
  logic         valid_nxt;
  cwd_decoded_t cfg_r;
  cwd_decoded_t cfg_nxt;
  logic         wdog_run_r;
  logic         wdog_run_nxt;

  // Bus side state.
  logic [31:0]  rdata_r;
  logic [31:0]  rdata_nxt;
  logic         err_r;
  logic         err_nxt;
  logic         reload_req;
  logic [23:0]  view_two;
  logic [23:0]  view_one;
  logic [15:0]  idx;
  logic         idx_hit_hi;

  // ------------------------------------------------------------------
  // Read-back view and field decode
  // ------------------------------------------------------------------
  assign view_two = shadow_two_r | CWD_TWO_FORCE1;
  assign view_one = shadow_one_r | CWD_ONE_FORCE1;

  function automatic cwd_decoded_t decode(input logic [23:0] w2, input logic [23:0] w1);
    cwd_decoded_t d;
    cwd_osc_t     sel;
    cwd_pri_t     pri;
    logic         xtal;
    sel = cwd_osc_t'(w2[CWD_W2_OSC_LSB +: 3]);
    pri = cwd_pri_t'(w2[CWD_W2_PRI_LSB +: 2]);
    xtal = (pri == pri_ms_xtal) || (pri == pri_hs_xtal);
    d.code_protect_en     = ~w1[CWD_W1_CODE_PROT];
    d.write_protect_en    = ~w1[CWD_W1_WRITE_PROT];
    d.two_speed_startup   = w2[CWD_W2_TWO_SPEED];
    d.start_osc           = w2[CWD_W2_TWO_SPEED] ? osc_fast_rc : sel;
    d.initial_osc_sel     = sel;
    d.osc_sel_reserved    = (sel == osc_reserved);
    d.pwm_key_lock        = w2[CWD_W2_PWM_LOCK];
    d.pwm_pins_tristate   = w2[CWD_W2_PWM_PIN];
    unique case (w2[CWD_W2_WIN_LSB +: 2])
      2'h3: d.wdog_window_eighths = 3'h2;
      2'h2: d.wdog_window_eighths = 3'h3;
      2'h1: d.wdog_window_eighths = 3'h4;
      2'h0: d.wdog_window_eighths = 3'h6;
    endcase
    d.clk_switch_en       = ~w2[CWD_W2_CKSM_LSB + 1];
    d.fail_safe_en        = (w2[CWD_W2_CKSM_LSB +: 2] == 2'h0);
    d.pinmap_one_shot     = w2[CWD_W2_PINMAP_ONCE];
    d.osc_pin_clkout      = ~xtal & w2[CWD_W2_OSC_PIN_FN];
    d.osc_pin_gpio        = ~xtal & ~w2[CWD_W2_OSC_PIN_FN];
    d.primary_osc_mode    = pri;
    d.primary_osc_en      = (pri != pri_disabled);
    d.wdog_force_enable   = w1[CWD_W1_WDOG_FORCE];
    d.wdog_window_mode    = ~w1[CWD_W1_WIN_DIS];
    d.pll_lock_wait       = w1[CWD_W1_PLL_WAIT];
    d.wdog_prescale_log2  = w1[CWD_W1_PRESCALE] ? CWD_PRE_LOG2_HI : CWD_PRE_LOG2_LO;
    d.wdog_postscale_log2 = w1[CWD_W1_POST_LSB +: 4];
    d.debug_pair          = 2'h0;
    unique case (w1[CWD_W1_DBG_LSB +: 2])
      2'h3: d.debug_pair = 2'h1;
      2'h2: d.debug_pair = 2'h2;
      2'h1: d.debug_pair = 2'h3;
      2'h0: d.debug_pair = 2'h0;
    endcase
    d.debug_sel_reserved  = (w1[CWD_W1_DBG_LSB +: 2] == 2'h0);
    d.high_side_active_high = w1[CWD_W1_HIGH_POL];
    d.low_side_active_high  = w2[CWD_W2_LOW_POL];
    d.alt_two_wire_pins   = w2[CWD_W2_ALT_TWI];
    return d;
  endfunction

  // ------------------------------------------------------------------
  // Loader
  // ------------------------------------------------------------------
  // The decoded image changes only at the end of a load, so a reload
  // never shows a half-updated pair of words.
  always_comb begin
    state_nxt      = state_r;
    shadow_two_nxt = shadow_two_r;
    shadow_one_nxt = shadow_one_r;
    flash_addr_nxt = flash_addr_r;
    valid_nxt      = valid_r;
    cfg_nxt        = cfg_r;
    unique case (state_r)
      st_req_two: begin
        flash_addr_nxt = FLASH_TWO;
        state_nxt      = st_wait_two;
      end
      st_wait_two: begin
        if (flash_rvalid) begin
          shadow_two_nxt = flash_rdata;
          flash_addr_nxt = FLASH_ONE;
          state_nxt      = st_req_one;
        end
      end
      st_req_one: begin
        state_nxt = st_wait_one;
      end
      st_wait_one: begin
        if (flash_rvalid) begin
          shadow_one_nxt = flash_rdata;
          state_nxt      = st_done;
        end
      end
      st_done: begin
        if (!valid_r) begin
          cfg_nxt   = decode(view_two, view_one);
          valid_nxt = 1'b1;
        end else if (reload_req) begin
          valid_nxt = 1'b0;
          state_nxt = st_req_two;
        end
      end
      default: begin
        valid_nxt = 1'b0;
        state_nxt = st_req_two;
      end
    endcase
  end

  always_comb begin
    wdog_run_nxt = valid_r & (cfg_r.wdog_force_enable | sw_wdog_enable);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r      <= st_req_two;
      shadow_two_r <= CWD_TWO_RESET;
      shadow_one_r <= CWD_ONE_RESET;
      flash_addr_r <= 24'h00_0000;
      valid_r      <= 1'b0;
      cfg_r        <= '0;
      wdog_run_r   <= 1'b0;
    end else begin
      state_r      <= state_nxt;
      shadow_two_r <= shadow_two_nxt;
      shadow_one_r <= shadow_one_nxt;
      flash_addr_r <= flash_addr_nxt;
      valid_r      <= valid_nxt;
      cfg_r        <= cfg_nxt;
      wdog_run_r   <= wdog_run_nxt;
    end
  end

  assign flash_rd_en = (state_r == st_req_two) || (state_r == st_req_one);
  assign flash_addr  = flash_addr_r;
  assign cfg_valid   = valid_r;
  assign cfg         = cfg_r;
  assign wdog_run    = wdog_run_r;

  // ------------------------------------------------------------------
  // APB slave
  // ------------------------------------------------------------------
  // Read data and the error flag are prepared in the setup cycle, so the
  // access phase always completes in its first cycle.
  assign idx        = paddr[17:2];
  assign idx_hit_hi = (paddr[31:18] == 14'h0000) && (paddr[1:0] == 2'h0);

  always_comb begin
    rdata_nxt = rdata_r;
    err_nxt   = err_r;
    if (psel && !penable) begin
      rdata_nxt = 32'h0000_0000;
      err_nxt   = 1'b0;
      if (!idx_hit_hi) begin
        err_nxt = 1'b1;
      end else if (idx == CWD_IDX_CTRL) begin
        err_nxt = 1'b0;
      end else if (idx == CWD_IDX_STATUS) begin
        err_nxt = pwrite;
        rdata_nxt[CWD_ST_VALID] = valid_r;
        rdata_nxt[CWD_ST_BUSY]  = (state_r != st_done);
        rdata_nxt[CWD_ST_LARGE] = LARGE_FLASH;
        rdata_nxt[CWD_ST_OSCRS] = cfg_r.osc_sel_reserved;
        rdata_nxt[CWD_ST_DBGRS] = cfg_r.debug_sel_reserved;
      end else if (idx == IDX_TWO) begin
        err_nxt   = pwrite;
        rdata_nxt = {8'h00, view_two};
      end else if (idx == IDX_ONE) begin
        err_nxt   = pwrite;
        rdata_nxt = {8'h00, view_one};
      end else begin
        err_nxt = 1'b1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdata_r <= 32'h0000_0000;
      err_r   <= 1'b0;
    end else begin
      rdata_r <= rdata_nxt;
      err_r   <= err_nxt;
    end
  end

  assign pready     = psel & penable;
  assign pslverr    = psel & penable & err_r;
  assign prdata     = rdata_r;
  assign reload_req = psel & penable & pwrite & ~err_r & idx_hit_hi
                      & (idx == CWD_IDX_CTRL) & pwdata[0];

  // ------------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------------
  property p_load_then_valid;
    @(posedge pclk) disable iff (!presetn)
      (state_r == st_wait_one && flash_rvalid) |=> !cfg_valid ##1 cfg_valid;
  endproperty
  a_load_then_valid: assert property (p_load_then_valid)
    else $error("settings not valid two cycles after second word");

  property p_upper_ones;
    @(posedge pclk) disable iff (!presetn)
      (pready && !pslverr && !pwrite && idx_hit_hi && (idx == IDX_TWO || idx == IDX_ONE))
        |-> (prdata[23:16] == 8'hff && prdata[31:24] == 8'h00);
  endproperty
  a_upper_ones: assert property (p_upper_ones)
    else $error("config word upper byte not read as ones");

  property p_polarity_ones;
    @(posedge pclk) disable iff (!presetn)
      cfg_valid |-> (cfg.high_side_active_high && cfg.low_side_active_high);
  endproperty
  a_polarity_ones: assert property (p_polarity_ones)
    else $error("polarity position not forced to one");

  property p_code_protect;
    @(posedge pclk) disable iff (!presetn)
      (cfg_valid && state_r == st_done)
        |-> (cfg.code_protect_en == !shadow_one_r[CWD_W1_CODE_PROT]
             && cfg.write_protect_en == !shadow_one_r[CWD_W1_WRITE_PROT]);
  endproperty
  a_code_protect: assert property (p_code_protect)
    else $error("protection setting does not match word one");

  property p_two_speed;
    @(posedge pclk) disable iff (!presetn)
      cfg_valid |-> (cfg.start_osc == (cfg.two_speed_startup ? osc_fast_rc
                                                             : cfg.initial_osc_sel));
  endproperty
  a_two_speed: assert property (p_two_speed)
    else $error("start oscillator wrong for two-speed setting");

  property p_window;
    @(posedge pclk) disable iff (!presetn)
      (cfg_valid && state_r == st_done && view_two[CWD_W2_WIN_LSB +: 2] == 2'h2)
        |-> cfg.wdog_window_eighths == 3'h3;
  endproperty
  a_window: assert property (p_window)
    else $error("window code 10 does not give 37.5 percent");

  property p_switch_mode;
    @(posedge pclk) disable iff (!presetn)
      cfg_valid |-> (!cfg.clk_switch_en |-> !cfg.fail_safe_en);
  endproperty
  a_switch_mode: assert property (p_switch_mode)
    else $error("monitor enabled while clock switching disabled");

  property p_wdog_force;
    @(posedge pclk) disable iff (!presetn)
      (cfg_valid && cfg.wdog_force_enable && !sw_wdog_enable) |=> wdog_run;
  endproperty
  a_wdog_force: assert property (p_wdog_force)
    else $error("forced watchdog stopped by software");

  property p_prescale;
    @(posedge pclk) disable iff (!presetn)
      cfg_valid |-> (cfg.wdog_prescale_log2 == 3'h7 || cfg.wdog_prescale_log2 == 3'h5);
  endproperty
  a_prescale: assert property (p_prescale)
    else $error("watchdog prescale not 128 or 32");

  property p_steady;
    @(posedge pclk) disable iff (!presetn)
      (cfg_valid && $past(cfg_valid)) |-> $stable(cfg);
  endproperty
  a_steady: assert property (p_steady)
    else $error("decoded settings changed while valid");

  property p_postscale;
    @(posedge pclk) disable iff (!presetn)
      (cfg_valid && state_r == st_done)
        |-> cfg.wdog_postscale_log2 == shadow_one_r[CWD_W1_POST_LSB +: 4];
  endproperty
  a_postscale: assert property (p_postscale)
    else $error("watchdog postscale does not match word one");

  property p_debug_pair;
    @(posedge pclk) disable iff (!presetn)
      (cfg_valid && state_r == st_done)
        |-> cfg.debug_pair == 2'(2'h0 - shadow_one_r[CWD_W1_DBG_LSB +: 2]);
  endproperty
  a_debug_pair: assert property (p_debug_pair)
    else $error("debug pin pair does not match word one");

endmodule

// File: dv/cwd_flash_model.sv
// Purpose: Flash and programmer model that holds the two configuration words.
// Assumes: One word request at a time, answered after delay cycles.
// Notes:   Data lines toggle whenever no answer is presented.
`timescale 1ns/1ps
module cwd_flash_model (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        flash_rd_en,
  input  wire logic [23:0] flash_addr,
  input  wire logic [23:0] word_two,
  input  wire logic [23:0] word_one,
  input  wire logic [7:0]  delay,
  output logic      [23:0] flash_rdata,
  output logic             flash_rvalid
);
  import cwd_pkg::*;
  logic [7:0]  cnt_r;
  logic        pend_r;
  logic [23:0] one_prog;
  // The programmer clears every bit above bit 13 and sets the tool bit.
  assign one_prog = (word_one & 24'h00_3fff) | 24'h00_0800;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r <= 8'h00;
      pend_r <= 1'b0;
      flash_rvalid <= 1'b0;
      flash_rdata <= 24'h00_0000;
    end else begin
      flash_rvalid <= 1'b0;
      flash_rdata <= ~flash_rdata;
      if (flash_rd_en) begin
        pend_r <= 1'b1;
        cnt_r <= delay;
      end else if (pend_r && cnt_r > 8'h01) begin
        cnt_r <= cnt_r - 8'h01;
      end else if (pend_r) begin
        pend_r <= 1'b0;
        flash_rvalid <= 1'b1;
        if (flash_addr === CWD_FLASH_TWO_SMALL) begin
          flash_rdata <= word_two;
        end else if (flash_addr === CWD_FLASH_ONE_SMALL) begin
          flash_rdata <= one_prog;
        end
      end
    end
  end
endmodule

// File: dv/tb_top.sv
// Purpose: Self-checking bench for the configuration word decoder.
// Assumes: Small flash variant, zero-wait APB slave.
// Notes:   Expected settings are rebuilt from the field meanings.
`timescale 1ns/1ps
module tb_top;
  import cwd_pkg::*;
  logic         pclk;
  logic         presetn;
  logic         psel;
  logic         penable;
  logic         pwrite;
  logic [31:0]  paddr;
  logic [31:0]  pwdata;
  logic         pready;
  logic         pslverr;
  logic [31:0]  prdata;
  logic         flash_rd_en;
  logic [23:0]  flash_addr;
  logic [23:0]  flash_rdata;
  logic         flash_rvalid;
  logic         sw_wdog_enable;
  logic         wdog_run;
  logic         cfg_valid;
  cwd_decoded_t cfg;
  logic [23:0]  word_two;
  logic [23:0]  word_one;
  logic [7:0]   delay;
  int           n_fail;
  int           n_checks;

  cwd_top #(.LARGE_FLASH(1'b0)) i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .pslverr(pslverr), .prdata(prdata), .flash_rd_en(flash_rd_en), .flash_addr(flash_addr),
    .flash_rdata(flash_rdata), .flash_rvalid(flash_rvalid), .sw_wdog_enable(sw_wdog_enable),
    .wdog_run(wdog_run), .cfg_valid(cfg_valid), .cfg(cfg));
  cwd_flash_model i_flash (.pclk(pclk), .presetn(presetn), .flash_rd_en(flash_rd_en),
    .flash_addr(flash_addr), .word_two(word_two), .word_one(word_one), .delay(delay),
    .flash_rdata(flash_rdata), .flash_rvalid(flash_rvalid));

  task automatic test_done();
    $display("Checks %0d, mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic chk_w(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("FAIL %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic chk_cfg(input cwd_decoded_t got, input cwd_decoded_t exp);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("FAIL %0t settings got %h exp %h", $time, got, exp);
    end
  endtask

  function automatic cwd_decoded_t exp_cfg(input logic [23:0] w2, input logic [23:0] w1);
    cwd_decoded_t e;
    logic         xt;
    xt = (w2[1:0] == 2'h1) || (w2[1:0] == 2'h2);
    e.code_protect_en = ~w1[13];
    e.write_protect_en = ~w1[12];
    e.two_speed_startup = w2[15];
    e.initial_osc_sel = cwd_osc_t'(w2[10:8]);
    e.start_osc = w2[15] ? osc_fast_rc : e.initial_osc_sel;
    e.osc_sel_reserved = (w2[10:8] == 3'h6);
    e.pwm_key_lock = w2[14];
    e.pwm_pins_tristate = w2[13];
    e.wdog_window_eighths = (w2[12:11] == 2'h3) ? 3'h2 : (w2[12:11] == 2'h2) ? 3'h3 :
                            (w2[12:11] == 2'h1) ? 3'h4 : 3'h6;
    e.clk_switch_en = ~w2[7];
    e.fail_safe_en = (w2[7:6] == 2'h0);
    e.pinmap_one_shot = w2[4];
    e.osc_pin_clkout = w2[5] & ~xt;
    e.osc_pin_gpio = ~w2[5] & ~xt;
    e.primary_osc_mode = cwd_pri_t'(w2[1:0]);
    e.primary_osc_en = (w2[1:0] != 2'h3);
    e.wdog_force_enable = w1[7];
    e.wdog_window_mode = ~w1[6];
    e.pll_lock_wait = w1[5];
    e.wdog_prescale_log2 = w1[4] ? 3'h7 : 3'h5;
    e.wdog_postscale_log2 = w1[3:0];
    e.debug_pair = 2'h0 - w1[9:8];
    e.debug_sel_reserved = (w1[9:8] == 2'h0);
    e.high_side_active_high = 1'b1;
    e.low_side_active_high = 1'b1;
    e.alt_two_wire_pins = w2[2];
    return e;
  endfunction

  task automatic acc(input logic wr, input logic [31:0] a, input logic [31:0] d,
                     input logic [31:0] ex, input logic ee);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    chk_w({31'h0, pready}, 32'h1, "no ready");
    chk_w({31'h0, pslverr}, {31'h0, ee}, "slave error");
    if (!wr && !ee) begin
      chk_w(prdata, ex, "read data");
    end
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wait_valid();
    int n;
    n = 0;
    while (cfg_valid !== 1'b1 && n < 300) begin
      @(posedge pclk);
      n++;
    end
    chk_w({31'h0, cfg_valid}, 32'h1, "load done");
  endtask

  task automatic judge(input logic [23:0] w2, input logic [23:0] w1);
    chk_cfg(cfg, exp_cfg(w2, w1));
    acc(1'b0, 32'h0000_aff0, 32'h0, {8'h00, 8'hff, w2[15:4], 1'b1, w2[2:0]}, 1'b0);
    acc(1'b0, 32'h0000_aff8, 32'h0, {8'h00, 8'hff, w1[15:11], 1'b1, w1[9:0]}, 1'b0);
    acc(1'b0, 32'h0000_0004, 32'h0, {27'h0, w1[9:8] == 2'h0, w2[10:8] == 3'h6, 3'h1}, 1'b0);
    chk_w({31'h0, wdog_run}, {31'h0, w1[7] | sw_wdog_enable}, "watchdog run");
  endtask

  task automatic s_factory();
    acc(1'b0, 32'h0000_aff0, 32'h0, 32'h00ff_ffdf, 1'b0);
    acc(1'b0, 32'h0000_aff8, 32'h0, 32'h00ff_ffff, 1'b0);
    acc(1'b0, 32'h0000_0004, 32'h0, 32'h0000_0002, 1'b0);
    chk_w({31'h0, cfg_valid}, 32'h0, "valid early");
    wait_valid();
    judge(word_two, word_one);
  endtask

  task automatic load(input logic [23:0] w2, input logic [23:0] w1, input logic [7:0] dl);
    int n;
    word_two <= w2;
    word_one <= w1;
    delay <= dl;
    acc(1'b1, 32'h0000_0000, 32'h0000_0001, 32'h0, 1'b0);
    n = 0;
    while (cfg_valid !== 1'b0 && n < 4) begin
      @(posedge pclk);
      n++;
    end
    chk_w({31'h0, cfg_valid}, 32'h0, "reload start");
    wait_valid();
    judge(w2, w1);
  endtask

  task automatic s_refuse();
    acc(1'b1, 32'h0000_aff0, 32'h0000_0000, 32'h0, 1'b1);
    acc(1'b1, 32'h0000_aff8, 32'h0000_0000, 32'h0, 1'b1);
    acc(1'b1, 32'h0000_0004, 32'h0000_ffff, 32'h0, 1'b1);
    acc(1'b0, 32'h0000_0008, 32'h0, 32'h0, 1'b1);
    acc(1'b0, 32'h0001_5ff0, 32'h0, 32'h0, 1'b1);
    acc(1'b0, 32'h0000_aff2, 32'h0, 32'h0, 1'b1);
    judge(word_two, word_one);
  endtask

  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end

  initial begin
    logic [2:0] k;
    n_fail = 0;
    n_checks = 0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 32'h0;
    pwdata = 32'h0;
    sw_wdog_enable = 1'b0;
    word_two = 24'h00_a5c6;
    word_one = 24'h00_1a9c;
    delay = 8'h28;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    s_factory();
    for (int i = 0; i < 8; i++) begin
      k = i[2:0];
      sw_wdog_enable <= k[1];
      load({k[0], k[1], k[2], k[1:0], k, k[1:0], k[2], k[0], ~k[0], k[1], k[1:0]},
           {2'h0, k[0], k[1], 1'b1, k[0], k[1:0], k[2], k[0], k[1], k[2], k, k[0]},
           k[0] ? 8'h01 : 8'h09);
    end
    s_refuse();
    test_done();
  end

  initial begin
    #(50 * 5000);
    chk_w(32'h0, 32'h1, "timeout");
    test_done();
  end
endmodule
